/* File: dac_gain_offset_calibration.v */
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "dac_cal_regs.vh"

module dac_gain_offset_calibration (
   input  wire        clock,
   input  wire        srst,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [9:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   output reg         cal_enable,
   output reg         dac_load_strobe,
   output reg  [2:0]  dac_load_index,
   output reg  [15:0] dac_load_word
);
   localparam [3:0] S_IDLE  = 4'b0001;
   localparam [3:0] S_CALC0 = 4'b0010;
   localparam [3:0] S_CALC1 = 4'b0100;
   localparam [3:0] S_RESP  = 4'b1000;

   // Input word location: index = base + chsel*4 + dac, chsel 2 = both channels
   function is_input;
      input [7:0] idx;
      begin
         is_input = (idx >= `IDX_IN_BASE) && (idx <= `IDX_IN_LAST);
      end
   endfunction

   function [2:0] slot_of;
      input [7:0] idx;
      input       ch;
      begin
         slot_of = {ch, idx[1:0]};
      end
   endfunction

   function is_set_reg;
      input [7:0] idx;
      begin
         is_set_reg = ((idx & `IDX_SET_MASK) == `IDX_GAIN_BASE) ||
                      ((idx & `IDX_SET_MASK) == `IDX_OFS_BASE);
         is_set_reg = is_set_reg && (idx[4] == 1'b0);
      end
   endfunction

   reg  [3:0]  state_r;
   reg  [3:0]  state_nxt;
   reg  [15:0] gain_r    [0:15];
   reg  [15:0] offset_r  [0:15];
   reg  [15:0] loaded_r  [0:7];
   reg  [7:0]  mode_r;
   reg  [15:0] raw_r;
   reg  [2:0]  slot_r;
   reg         both_r;
   reg         alu_start;
   reg  [2:0]  alu_slot;
   reg  [15:0] alu_x;
   reg  [31:0] rdata_nxt;
   reg         err_nxt;
   integer     i;

   wire [7:0]  idx     = paddr[9:2];
   wire        access  = psel && penable;
   wire        in_hit  = is_input(idx) && (idx[3:2] != 2'h3);
   wire        both    = (idx[3:2] == `CHSEL_BOTH);
   wire [3:0]  set_sel = {alu_slot, mode_r[alu_slot]};
   wire [15:0] alu_y;
   wire        alu_valid;

   gain_offset_alu u_alu (
      .clock               (clock),
      .srst                (srst),
      .start               (alu_start),
      .cal_en              (cal_enable),
      .raw_input_word      (alu_x),
      .gain                (gain_r[set_sel]),
      .offset              (offset_r[set_sel]),
      .corrected_load_word (alu_y),
      .valid               (alu_valid)
   );

   // Launch the ALU: first channel from the bus, second from the held word
   always @* begin
      alu_start = 1'b0;
      alu_slot  = slot_r;
      alu_x     = raw_r;
      if (state_r == S_IDLE && access && pwrite && in_hit) begin
         alu_start = 1'b1;
         alu_slot  = both ? slot_of(idx, 1'b0) : slot_of(idx, idx[2]);
         alu_x     = pwdata[15:0];
      end else if (state_r == S_CALC0 && both_r) begin
         alu_start = 1'b1;
         alu_slot  = {1'b1, slot_r[1:0]};
      end
   end

   // Read data and error for every access except an input-word write
   always @* begin
      rdata_nxt = 32'h00000000;
      err_nxt   = 1'b0;
      if (in_hit)
         rdata_nxt = {16'h0000, loaded_r[both ? slot_of(idx, 1'b0)
                                              : slot_of(idx, idx[2])]};
      else if (idx == `IDX_CTRL)
         rdata_nxt = {31'h00000000, cal_enable};
      else if (idx == `IDX_MODE)
         rdata_nxt = {24'h000000, mode_r};
      else if (is_set_reg(idx))
         rdata_nxt = {16'h0000, idx[5] ? offset_r[idx[3:0]] : gain_r[idx[3:0]]};
      else
         err_nxt = 1'b1;
   end

   always @* begin
      state_nxt = state_r;
      case (state_r)
         S_IDLE: begin
            if (access)
               state_nxt = (pwrite && in_hit) ? S_CALC0 : S_RESP;
         end
         S_CALC0: begin
            state_nxt = both_r ? S_CALC1 : S_RESP;
         end
         S_CALC1: begin
            state_nxt = S_RESP;
         end
         S_RESP: begin
            state_nxt = S_IDLE;
         end
         default: begin
            state_nxt = S_IDLE;
         end
      endcase
   end

   always @(posedge clock) begin
      if (srst) begin
         state_r         <= S_IDLE;
         pready          <= 1'b0;
         pslverr         <= 1'b0;
         prdata          <= 32'h00000000;
         cal_enable      <= `CTRL_RST;
         mode_r          <= `MODE_RST;
         raw_r           <= `WORD_MIN;
         slot_r          <= 3'h0;
         both_r          <= 1'b0;
         dac_load_strobe <= 1'b0;
         dac_load_index  <= 3'h0;
         dac_load_word   <= `WORD_MIN;
         // Volatile: every reset restores defaults
         for (i = 0; i < 16; i = i + 1) begin
            gain_r[i]   <= `GAIN_RST;
            offset_r[i] <= `OFS_RST;
         end
         for (i = 0; i < 8; i = i + 1)
            loaded_r[i] <= `WORD_MIN;
      end else begin
         state_r         <= state_nxt;
         dac_load_strobe <= 1'b0;
         case (state_r)
            S_IDLE: begin
               pready  <= 1'b0;
               pslverr <= 1'b0;
               if (access) begin
                  raw_r  <= pwdata[15:0];
                  slot_r <= alu_slot;
                  both_r <= both;
                  if (!(pwrite && in_hit)) begin
                     pready  <= 1'b1;
                     pslverr <= err_nxt;
                     prdata  <= pwrite ? 32'h00000000 : rdata_nxt;
                  end
               end
            end
            S_CALC0, S_CALC1: begin
               // One corrected word per DAC, overwritten on every load
               if (alu_valid) begin
                  loaded_r[slot_r] <= alu_y;
                  dac_load_strobe  <= 1'b1;
                  dac_load_index   <= slot_r;
                  dac_load_word    <= alu_y;
               end
               if (state_r == S_CALC0 && both_r) begin
                  slot_r <= {1'b1, slot_r[1:0]};
               end else begin
                  // Writes answer with zero data, never a stale read word
                  pready <= 1'b1;
                  prdata <= 32'h00000000;
               end
            end
            S_RESP: begin
               pready  <= 1'b0;
               pslverr <= 1'b0;
               // Register writes land at the edge the master sees pready
               if (access && pwrite && !pslverr) begin
                  if (idx == `IDX_CTRL)
                     cal_enable <= pwdata[`CTRL_CAL_EN];
                  else if (idx == `IDX_MODE)
                     mode_r <= pwdata[7:0];
                  else if (is_set_reg(idx) && idx[5])
                     offset_r[idx[3:0]] <= pwdata[15:0];
                  else if (is_set_reg(idx))
                     gain_r[idx[3:0]] <= pwdata[15:0];
               end
            end
            default: begin
               pready <= 1'b0;
            end
         endcase
      end
   end
endmodule // dac_gain_offset_calibration

`default_nettype wire

/* File: dac_cal_regs.vh */
`ifndef DAC_CAL_REGS_VH
`define DAC_CAL_REGS_VH

`define DW             16
`define DAC_RES        16
`define HALF_SCALE     17'h08000
`define GAIN_RST       16'hffff
`define OFS_RST        16'h8000
`define WORD_MAX       16'hffff
`define WORD_MIN       16'h0000

`define IDX_CTRL       8'h11
`define IDX_MODE       8'h12
`define IDX_IN_BASE    8'h40
`define IDX_IN_LAST    8'h4b
`define IDX_GAIN_BASE  8'h80
`define IDX_OFS_BASE   8'ha0
`define IDX_SET_MASK   8'he0

`define CTRL_CAL_EN    0
`define CTRL_RST       1'b1
`define MODE_RST       8'h00
`define CHSEL_BOTH     2'h2

`endif

/* File: gain_offset_alu.v */
`timescale 1ns/100ps
`default_nettype none
`include "dac_cal_regs.vh"

module gain_offset_alu (
   input  wire        clock,
   input  wire        srst,
   input  wire        start,
   input  wire        cal_en,
   input  wire [15:0] raw_input_word,
   input  wire [15:0] gain,
   input  wire [15:0] offset,
   output reg  [15:0] corrected_load_word,
   output reg         valid
);
   wire [16:0] gain_p1  = {1'b0, gain} + 17'h00001;
   wire [32:0] product  = raw_input_word * gain_p1;
   // Truncation drops the fraction; no rounding so default gain is exact
   wire [16:0] scaled   = product[32:`DAC_RES];
   // Offset added after scaling, in raw steps
   wire signed [18:0] sum = $signed({2'b00, scaled}) + $signed({3'b000, offset})
                            - $signed({2'b00, `HALF_SCALE});
   reg  [15:0] result;

   always @* begin
      if (!cal_en)
         result = raw_input_word;
      else if (sum < 0)
         result = `WORD_MIN;
      else if (sum > $signed({3'b000, `WORD_MAX}))
         result = `WORD_MAX;
      else
         result = sum[15:0];
   end

   always @(posedge clock) begin
      if (srst) begin
         corrected_load_word <= `WORD_MIN;
         valid               <= 1'b0;
      end else begin
         valid <= start;
         if (start)
            corrected_load_word <= result;
      end
   end
endmodule // gain_offset_alu

`default_nettype wire

/* File: dac_cal_props.sv */
`timescale 1ns/100ps
`default_nettype none
module dac_cal_props (
   input wire logic        clock,
   input wire logic        srst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [9:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        cal_enable,
   input wire logic        dac_load_strobe,
   input wire logic [2:0]  dac_load_index,
   input wire logic [15:0] dac_load_word
);
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   sequence acc;
      psel && $rose(penable);
   endsequence
   sequence in_wr;
      acc ##0 pwrite && paddr[9:6] == 4'h4 && paddr[5:4] != 2'h3;
   endsequence
   sequence ctl(w);
      acc ##0 pwrite == w && paddr[9:2] == 8'h11;
   endsequence
   AST_BYPASS_LOAD: assert property (in_wr ##0 !cal_enable |-> ##2 dac_load_strobe && dac_load_word == $past(pwdata[15:0], 2)) else $error("bypass word altered");
   AST_SINGLE_SLOT: assert property (in_wr ##0 paddr[5:4] != 2'h2 |-> ##2 dac_load_strobe && pready && !pslverr && dac_load_index == {$past(paddr[4], 2), $past(paddr[3:2], 2)}) else $error("single load wrong");
   AST_DUAL_SEQ: assert property (in_wr ##0 paddr[5:4] == 2'h2 |-> ##2 dac_load_strobe && dac_load_index == {1'b0, $past(paddr[3:2], 2)} ##1 dac_load_strobe && pready && dac_load_index == {1'b1, $past(paddr[3:2], 3)}) else $error("dual load order wrong");
   AST_LOAD_CAUSE: assert property (dac_load_strobe |-> $past(psel && penable && pwrite && paddr[9:6] == 4'h4)) else $error("load without input write");
   AST_NO_COEF_LOAD: assert property (acc ##0 pwrite && paddr[9] |-> !dac_load_strobe [*3]) else $error("coefficient write loaded");
   AST_CTRL_WRITE: assert property (ctl(1'b1) |-> ##1 pready ##1 cal_enable == $past(pwdata[0], 2)) else $error("enable not taken");
   AST_CTRL_READ: assert property (ctl(1'b0) |-> ##1 pready && prdata == {31'h0, cal_enable}) else $error("enable readback wrong");
   AST_ONE_WORD: assert property (in_wr ##0 paddr[5:4] != 2'h2 |-> ##2 dac_load_strobe ##1 !dac_load_strobe) else $error("repeated load");
endmodule // dac_cal_props
bind dac_gain_offset_calibration dac_cal_props dac_cal_props_i (.clock, .srst, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cal_enable, .dac_load_strobe,
   .dac_load_index, .dac_load_word);
`default_nettype wire

/* File: host_apb.sv */
`timescale 1ns/100ps
`default_nettype none
module host_apb (
   input  wire logic        clock,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr,
   output var  logic        psel,
   output var  logic        penable,
   output var  logic        pwrite,
   output var  logic [9:0]  paddr,
   output var  logic [31:0] pwdata
);
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
   end
   // Opens one edge after the call so release and setup never share a time step
   task xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
             output logic [31:0] q, output logic e);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
   endtask
endmodule // host_apb
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic             clock = 1'b0;
   logic             srst = 1'b1;
   wire logic        psel, penable, pwrite, pready, pslverr, cal_enable, dac_load_strobe;
   wire logic [9:0]  paddr;
   wire logic [31:0] pwdata, prdata;
   wire logic [2:0]  dac_load_index;
   wire logic [15:0] dac_load_word;
   int               mismatches = 0;
   int               comparisons = 0;
   logic [31:0]      q;
   logic             e;
   always #10 clock = ~clock;
   dac_gain_offset_calibration dac_gain_offset_calibration_i (.clock, .srst, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cal_enable, .dac_load_strobe,
      .dac_load_index, .dac_load_word);
   host_apb host_apb_i (.clock, .pready, .prdata, .pslverr, .psel, .penable, .pwrite, .paddr,
      .pwdata);
   task chk(input logic [31:0] seen, input logic [31:0] want);
      comparisons++;
      if (seen !== want) begin
         mismatches++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, want);
      end
   endtask
   task wr(input logic [9:0] a, input logic [31:0] d);
      host_apb_i.xfer(1'b1, a, d, q, e);
   endtask
   task rc(input logic [9:0] a, input logic [31:0] want);
      host_apb_i.xfer(1'b0, a, 32'h0, q, e);
      chk(q, want);
   endtask
   // Wide sum so the saturation test sees the true overflow
   function automatic logic [31:0] cal(input logic [15:0] x, m, c);
      logic [33:0] t;
      t = ((x * ({1'b0, m} + 17'h1)) >> 16) + c;
      if (t < 34'h8000) return 32'h0;
      if (t > 34'h17fff) return 32'hffff;
      return {16'h0, t[15:0] - 16'h8000};
   endfunction
   task close_out;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task do_reset;
      srst <= 1'b1;
      repeat (3) @(posedge clock);
      srst <= 1'b0;
   endtask
   initial begin
      do_reset;
      rc(10'h044, 32'h1);
      rc(10'h200, 32'hffff);
      rc(10'h280, 32'h8000);
      wr(10'h100, 32'hffff_1234);
      rc(10'h100, 32'h1234);
      wr(10'h200, 32'h7fff);
      wr(10'h280, 32'h8010);
      rc(10'h100, 32'h1234);
      wr(10'h100, 32'h1234);
      rc(10'h100, cal(16'h1234, 16'h7fff, 16'h8010));
      wr(10'h220, 32'h3fff);
      wr(10'h120, 32'h8000);
      rc(10'h100, cal(16'h8000, 16'h7fff, 16'h8010));
      rc(10'h110, cal(16'h8000, 16'h3fff, 16'h8000));
      wr(10'h048, 32'h1);
      wr(10'h284, 32'h0);
      rc(10'h100, cal(16'h8000, 16'h7fff, 16'h8010));
      wr(10'h100, 32'h0100);
      rc(10'h100, cal(16'h0100, 16'hffff, 16'h0));
      wr(10'h284, 32'hffff);
      wr(10'h100, 32'hffff);
      rc(10'h100, 32'hffff);
      wr(10'h044, 32'h0);
      rc(10'h044, 32'h0);
      wr(10'h100, 32'h0100);
      wr(10'h114, 32'habcd);
      rc(10'h100, 32'h0100);
      rc(10'h114, 32'habcd);
      rc(10'h130, 32'h0);
      chk({31'h0, e}, 32'h1);
      wr(10'h044, 32'h1);
      wr(10'h128, 32'h0010);
      do_reset;
      rc(10'h200, 32'hffff);
      rc(10'h044, 32'h1);
      close_out;
   end
   initial begin
      repeat (5000) @(posedge clock);
      mismatches++;
      close_out;
   end
endmodule // testbench
`default_nettype wire
